/* File: core/mcp_counter_pwm.sv */
// Modulus counter with prescaler and a PWM compare channel on its bus.
`timescale 1ns/1ps
module mcp_counter_pwm #(
    parameter int PRE_W = 8,
    parameter int CNT_W = 16
) (
    input wire logic ref_clk_i,
    input wire logic reset_i,
    input wire logic clk_en_i,
    input wire logic [3:0] addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [15:0] rdata_o,
    output logic bus_error_o,
    input wire logic ext_clk_i,
    input wire logic ext_load_i,
    output logic [CNT_W-1:0] counter_bus_o,
    output logic pwm_o
);
    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [1:0] clk_sync_q;
    logic [1:0] load_sync_q;
    logic clk_prev_q;
    logic load_prev_q;
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            clk_sync_q <= 2'h0;
            load_sync_q <= 2'h0;
            clk_prev_q <= 1'b0;
            load_prev_q <= 1'b0;
        end else if (clk_en_i) begin
            clk_sync_q <= {clk_sync_q[0], ext_clk_i};
            load_sync_q <= {load_sync_q[0], ext_load_i};
            clk_prev_q <= clk_sync_q[1];
            load_prev_q <= load_sync_q[1];
        end
    end

    // ------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------
    logic [CNT_W-1:0] counter_q;
    logic [CNT_W-1:0] modulus_q;
    logic [PRE_W-1:0] pre_reg_q;
    logic [PRE_W-1:0] pre_cnt_q;
    logic [6:0] cnt_ctrl_q;
    logic [6:0] da_ctrl_q;
    logic [CNT_W-1:0] reg_a_q;
    logic [CNT_W-1:0] trail_edge_buffer_q;
    logic [CNT_W-1:0] trail_edge_active_q;
    logic a_written_q;
    logic b_written_q;
    logic bus_err_en_q;
    logic wr_counter;
    logic wr_modulus;
    assign wr_counter = wr_i && addr_i == mcp_pkg::OFF_COUNTER;
    assign wr_modulus = wr_i && addr_i == mcp_pkg::OFF_MODULUS;

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            pre_reg_q <= mcp_pkg::RST_PRESCALE;
            cnt_ctrl_q <= mcp_pkg::RST_CNT_CTRL;
            da_ctrl_q <= mcp_pkg::RST_DA_CTRL;
            bus_err_en_q <= 1'b0;
        end else if (clk_en_i && wr_i) begin
            case (addr_i)
                mcp_pkg::OFF_PRESCALE: pre_reg_q <= wdata_i[PRE_W-1:0];
                mcp_pkg::OFF_CNT_CTRL: cnt_ctrl_q <= wdata_i[6:0];
                // Force bits are actions and are not stored.
                mcp_pkg::OFF_DA_CTRL: da_ctrl_q <= {2'h0, wdata_i[4:0]};
                mcp_pkg::OFF_CONFIG: bus_err_en_q <= wdata_i[0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            modulus_q <= mcp_pkg::RST_MODULUS;
        end else if (clk_en_i && (wr_counter || wr_modulus)) begin
            modulus_q <= wdata_i[CNT_W-1:0];
        end
    end

    // ------------------------------------------------------------
    // Prescaler and clock select
    // ------------------------------------------------------------
    logic pre_tick;
    logic [PRE_W-1:0] pre_div_q;
    logic pre_tap;
    logic ext_edge;
    logic cnt_tick;
    assign pre_tick = pre_cnt_q == {PRE_W{1'b1}};
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            pre_cnt_q <= '0;
            pre_div_q <= '0;
        end else if (clk_en_i) begin
            pre_cnt_q <= pre_tick ? pre_reg_q : pre_cnt_q + 1'b1;
            if (pre_tick) begin
                pre_div_q <= pre_div_q + 1'b1;
            end
        end
    end

    always_comb begin
        case (cnt_ctrl_q[mcp_pkg::CC_CLKSEL_LSB +: 3])
            3'h0: pre_tap = pre_tick;
            default: pre_tap = pre_tick &&
                (pre_div_q[cnt_ctrl_q[2:0] - 3'h1] == 1'b1) &&
                (pre_div_q[cnt_ctrl_q[2:0] - 3'h1 -: 1] != 1'b0) &&
                (pre_div_q & ((PRE_W'(1) << (cnt_ctrl_q[2:0] - 3'h1))
                    - PRE_W'(1))) == '0;
        endcase
    end
    assign ext_edge = cnt_ctrl_q[mcp_pkg::CC_CLK_POL] ?
        (!clk_sync_q[1] && clk_prev_q) : (clk_sync_q[1] && !clk_prev_q);
    assign cnt_tick = cnt_ctrl_q[mcp_pkg::CC_EXT_CLK] ? ext_edge : pre_tap;

    // ------------------------------------------------------------
    // Up-counter
    // ------------------------------------------------------------
    logic load_edge;
    logic overflow;
    assign load_edge = cnt_ctrl_q[mcp_pkg::CC_LOAD_EN] &&
        (cnt_ctrl_q[mcp_pkg::CC_LOAD_POL] ?
        (!load_sync_q[1] && load_prev_q) : (load_sync_q[1] && !load_prev_q));
    assign overflow = cnt_tick && counter_q == {CNT_W{1'b1}};
    logic bus_update;
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            counter_q <= mcp_pkg::RST_COUNTER;
            bus_update <= 1'b0;
        end else if (clk_en_i) begin
            bus_update <= 1'b0;
            if (wr_counter) begin
                counter_q <= wdata_i[CNT_W-1:0];
                bus_update <= 1'b1;
            end else if (overflow || load_edge) begin
                counter_q <= modulus_q;
                bus_update <= 1'b1;
            end else if (cnt_tick) begin
                counter_q <= counter_q + 1'b1;
                bus_update <= 1'b1;
            end
        end
    end
    assign counter_bus_o = counter_q;

    // ------------------------------------------------------------
    // Compare channel
    // ------------------------------------------------------------
    logic pwm_mode;
    logic [CNT_W-1:0] cmp_mask;
    logic match_a;
    logic match_b;
    logic force_a;
    logic force_b;
    assign pwm_mode = da_ctrl_q[mcp_pkg::DC_PWM_BIT];
    assign cmp_mask = pwm_mode ?
        ~((CNT_W'(1) << (CNT_W'(da_ctrl_q[2:0]) + CNT_W'(8))) - CNT_W'(1)) |
        {{(CNT_W-8){1'b0}}, 8'hFF} : {CNT_W{1'b1}};
    assign match_a = bus_update && a_written_q &&
        ((counter_q & cmp_mask) == (reg_a_q & cmp_mask));
    assign match_b = bus_update && b_written_q &&
        ((counter_q & cmp_mask) == (trail_edge_active_q & cmp_mask));
    assign force_a = clk_en_i && wr_i && addr_i == mcp_pkg::OFF_DA_CTRL &&
        wdata_i[mcp_pkg::DC_FORCE_A];
    assign force_b = clk_en_i && wr_i && addr_i == mcp_pkg::OFF_DA_CTRL &&
        wdata_i[mcp_pkg::DC_FORCE_B];

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            reg_a_q <= '0;
            trail_edge_buffer_q <= '0;
            a_written_q <= 1'b0;
            b_written_q <= 1'b0;
        end else if (clk_en_i && wr_i) begin
            if (addr_i == mcp_pkg::OFF_DA_A) begin
                reg_a_q <= wdata_i[CNT_W-1:0];
                a_written_q <= 1'b1;
            end
            if (addr_i == mcp_pkg::OFF_DA_B) begin
                trail_edge_buffer_q <= wdata_i[CNT_W-1:0];
                b_written_q <= 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            trail_edge_active_q <= '0;
        end else if (clk_en_i) begin
            if ((match_a || match_b) || (!pwm_mode && b_written_q)) begin
                trail_edge_active_q <= trail_edge_buffer_q;
            end else if (pwm_mode && !b_written_q) begin
                trail_edge_active_q <= trail_edge_buffer_q;
            end
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            pwm_o <= 1'b0;
        end else if (clk_en_i) begin
            if (force_a) begin
                pwm_o <= !wdata_i[mcp_pkg::DC_EDGE_POL];
            end else if (force_b) begin
                pwm_o <= wdata_i[mcp_pkg::DC_EDGE_POL];
            end else if (!a_written_q && !b_written_q) begin
                pwm_o <= da_ctrl_q[mcp_pkg::DC_EDGE_POL];
            end else if (match_a) begin
                pwm_o <= !da_ctrl_q[mcp_pkg::DC_EDGE_POL];
            end else if (match_b) begin
                pwm_o <= da_ctrl_q[mcp_pkg::DC_EDGE_POL];
            end
        end
    end

    // ------------------------------------------------------------
    // Interrupt status words
    // ------------------------------------------------------------
    logic [15:0] flags_q;
    logic mc_event;
    logic da_event;
    assign mc_event = overflow;
    assign da_event = match_a;
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            flags_q <= '0;
        end else if (clk_en_i) begin
            if (wr_i && addr_i == mcp_pkg::OFF_FLAGS) begin
                flags_q <= flags_q & wdata_i & mcp_pkg::FLAG_WMASK;
            end
            if (mc_event) begin
                flags_q[mcp_pkg::FLAG_MC_BIT] <= 1'b1;
            end
            if (da_event) begin
                flags_q[mcp_pkg::FLAG_DA_BIT] <= 1'b1;
            end
        end
    end

    logic [15:0] pending;
    always_comb begin
        pending = '0;
        pending[mcp_pkg::PEND_MC_BIT] = flags_q[mcp_pkg::FLAG_MC_BIT];
        pending[mcp_pkg::PEND_DA_BIT] = flags_q[mcp_pkg::FLAG_DA_BIT];
    end

    // ------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            rdata_o <= '0;
            bus_error_o <= 1'b0;
        end else if (clk_en_i) begin
            rdata_o <= '0;
            bus_error_o <= wr_i && bus_err_en_q &&
                addr_i == mcp_pkg::OFF_PENDING;
            if (rd_i) begin
                case (addr_i)
                    mcp_pkg::OFF_COUNTER: rdata_o <= 16'(counter_q);
                    mcp_pkg::OFF_MODULUS: rdata_o <= 16'(modulus_q);
                    mcp_pkg::OFF_PRESCALE: rdata_o <= 16'(pre_reg_q);
                    mcp_pkg::OFF_CNT_CTRL: rdata_o <= {9'h000, cnt_ctrl_q};
                    mcp_pkg::OFF_DA_A: rdata_o <= 16'(reg_a_q);
                    mcp_pkg::OFF_DA_B: rdata_o <= 16'(trail_edge_buffer_q);
                    mcp_pkg::OFF_DA_CTRL: rdata_o <= {9'h000, da_ctrl_q};
                    mcp_pkg::OFF_PENDING: rdata_o <= pending;
                    mcp_pkg::OFF_FLAGS: rdata_o <= flags_q;
                    mcp_pkg::OFF_CONFIG: rdata_o <= {15'h0000, bus_err_en_q};
                    default: rdata_o <= '0;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_sw_load;
        @(posedge ref_clk_i) disable iff (reset_i)
        (clk_en_i && wr_counter) |=> counter_q == $past(wdata_i);
    endproperty
    a_sw_load: assert property (p_sw_load)
        else $error("Counter write did not load counter.");

    property p_overflow_reload;
        @(posedge ref_clk_i) disable iff (reset_i)
        (clk_en_i && overflow && !wr_counter) |=>
            counter_q == $past(modulus_q);
    endproperty
    a_overflow_reload: assert property (p_overflow_reload)
        else $error("Overflow did not reload modulus.");

    property p_load_edge;
        @(posedge ref_clk_i) disable iff (reset_i)
        (clk_en_i && load_edge && !wr_counter) |=>
            counter_q == $past(modulus_q);
    endproperty
    a_load_edge: assert property (p_load_edge)
        else $error("Load edge did not reload modulus.");

    property p_latch_only;
        @(posedge ref_clk_i) disable iff (reset_i)
        (clk_en_i && wr_modulus && !overflow && !load_edge && !cnt_tick)
            |=> counter_q == $past(counter_q);
    endproperty
    a_latch_only: assert property (p_latch_only)
        else $error("Latch write disturbed counter.");

    property p_flag_overflow;
        @(posedge ref_clk_i) disable iff (reset_i)
        (clk_en_i && overflow) |=> flags_q[mcp_pkg::FLAG_MC_BIT];
    endproperty
    a_flag_overflow: assert property (p_flag_overflow)
        else $error("Overflow flag not set.");

    property p_copy_b;
        @(posedge ref_clk_i) disable iff (reset_i)
        (clk_en_i && (match_a || match_b)) |=>
            trail_edge_active_q == $past(trail_edge_buffer_q);
    endproperty
    a_copy_b: assert property (p_copy_b)
        else $error("Trailing buffer not copied on match.");

    property p_lead;
        @(posedge ref_clk_i) disable iff (reset_i)
        (clk_en_i && match_a && !force_a && !force_b) |=>
            pwm_o == !$past(da_ctrl_q[mcp_pkg::DC_EDGE_POL]);
    endproperty
    a_lead: assert property (p_lead)
        else $error("Output not set on A match.");

    property p_pend_ro;
        @(posedge ref_clk_i) disable iff (reset_i)
        (clk_en_i && wr_i && addr_i == mcp_pkg::OFF_PENDING) |=>
            bus_error_o == $past(bus_err_en_q);
    endproperty
    a_pend_ro: assert property (p_pend_ro)
        else $error("Pending write error response wrong.");
endmodule : mcp_counter_pwm

/* File: pkg/mcp_pkg.sv */
// Package with register map, field positions and reset values of the counter block.
package mcp_pkg;
    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [3:0] OFF_COUNTER = 4'h0;
    localparam logic [3:0] OFF_MODULUS = 4'h1;
    localparam logic [3:0] OFF_PRESCALE = 4'h2;
    localparam logic [3:0] OFF_CNT_CTRL = 4'h3;
    localparam logic [3:0] OFF_DA_A = 4'h4;
    localparam logic [3:0] OFF_DA_B = 4'h5;
    localparam logic [3:0] OFF_DA_CTRL = 4'h6;
    localparam logic [3:0] OFF_PENDING = 4'h7;
    localparam logic [3:0] OFF_FLAGS = 4'h8;
    localparam logic [3:0] OFF_CONFIG = 4'h9;
    // ------------------------------------------------------------
    // Counter control fields
    // ------------------------------------------------------------
    localparam int CC_CLKSEL_LSB = 0;
    localparam int CC_EXT_CLK = 3;
    localparam int CC_CLK_POL = 4;
    localparam int CC_LOAD_POL = 5;
    localparam int CC_LOAD_EN = 6;
    // ------------------------------------------------------------
    // Compare channel control fields
    // ------------------------------------------------------------
    localparam int DC_MODE_LSB = 0;
    localparam int DC_PWM_BIT = 3;
    localparam int DC_EDGE_POL = 4;
    localparam int DC_FORCE_A = 5;
    localparam int DC_FORCE_B = 6;
    // ------------------------------------------------------------
    // Interrupt register fields
    // ------------------------------------------------------------
    localparam int PEND_MC_BIT = 8;
    localparam int PEND_DA_BIT = 4;
    localparam int FLAG_MC_BIT = 8;
    localparam int FLAG_DA_BIT = 4;
    localparam logic [15:0] FLAG_WMASK = 16'hFF9F;
    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [15:0] RST_COUNTER = 16'h0000;
    localparam logic [15:0] RST_MODULUS = 16'h0000;
    localparam logic [7:0] RST_PRESCALE = 8'h00;
    localparam logic [6:0] RST_CNT_CTRL = 7'h00;
    localparam logic [6:0] RST_DA_CTRL = 7'h00;
endpackage : mcp_pkg

/* File: verification/mcp_counter_pwm_bench.sv */
// Self-checking testbench of the modulus counter with PWM compare.
`timescale 1ns/1ps
module mcp_counter_pwm_bench;
    logic ref_clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic clk_en_i = 1'b1;
    logic [3:0] addr_i = 4'h0;
    logic [15:0] wdata_i = 16'h0000;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [15:0] rdata_o;
    logic bus_error_o;
    logic ext_clk;
    logic ext_load;
    logic [15:0] counter_bus_o;
    logic pwm_o;
    logic [15:0] rv;
    int num_errors = 0;
    int tests_run = 0;

    mcp_counter_pwm u_mcp_counter_pwm (
        .ref_clk_i(ref_clk_i), .reset_i(reset_i), .clk_en_i(clk_en_i),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
        .rdata_o(rdata_o), .bus_error_o(bus_error_o),
        .ext_clk_i(ext_clk), .ext_load_i(ext_load),
        .counter_bus_o(counter_bus_o), .pwm_o(pwm_o)
    );

    mcp_pin_model u_mcp_pin_model (
        .ref_clk_i(ref_clk_i), .ext_clk_o(ext_clk), .ext_load_o(ext_load)
    );

    always #50 ref_clk_i = ~ref_clk_i;

    // ------------------------------------------------------------
    // Bus and checking helpers
    // ------------------------------------------------------------
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge ref_clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge ref_clk_i);
        wr_i <= 1'b0;
        #1;
    endtask : wr

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            $display("ERROR at %0t got %h expected %h", $time, got, exp);
            num_errors++;
        end
    endtask : chk

    task automatic rdchk(input logic [3:0] a, input logic [15:0] exp,
                         input logic [15:0] mask);
        @(posedge ref_clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge ref_clk_i);
        rd_i <= 1'b0;
        #1;
        rv = rdata_o;
        chk(rv & mask, exp);
    endtask : rdchk

    task automatic wait_bus(input logic [15:0] v, input int n);
        for (int i = 0; i < n; i++) begin
            @(negedge ref_clk_i);
            if (counter_bus_o === v) break;
        end
        chk(counter_bus_o, v);
    endtask : wait_bus

    task automatic idle(input int n);
        repeat (n) @(posedge ref_clk_i);
        #1;
    endtask : idle

    task automatic chk_pwm(input logic e);
        chk({15'h0000, pwm_o}, {15'h0000, e});
    endtask : chk_pwm

    task automatic conclude();
        if (num_errors == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : conclude

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        chk(counter_bus_o, mcp_pkg::RST_COUNTER);
        rdchk(mcp_pkg::OFF_MODULUS, mcp_pkg::RST_MODULUS, 16'hFFFF);
        rdchk(mcp_pkg::OFF_PENDING, 16'h0000, 16'hFFFF);
        wr(4'hF, 16'hFFFF);
        rdchk(4'hF, 16'h0000, 16'hFFFF);
        wr(mcp_pkg::OFF_DA_CTRL, 16'h0010);
        idle(2);
        chk_pwm(1'b1);
        wr(mcp_pkg::OFF_DA_CTRL, 16'h0000);
        idle(2);
        chk_pwm(1'b0);
    endtask : t_reset

    task automatic t_loads();
        wr(mcp_pkg::OFF_COUNTER, 16'h1234);
        chk(counter_bus_o, 16'h1234);
        rdchk(mcp_pkg::OFF_MODULUS, 16'h1234, 16'hFFFF);
        wr(mcp_pkg::OFF_MODULUS, 16'h0010);
        idle(4);
        chk(counter_bus_o, 16'h1234);
    endtask : t_loads

    // Prescaler at 0xFF ticks the counter on every clock.
    task automatic t_overflow();
        wr(mcp_pkg::OFF_PRESCALE, 16'h00FF);
        wr(mcp_pkg::OFF_COUNTER, 16'hFFF0);
        wr(mcp_pkg::OFF_MODULUS, 16'h0010);
        wait_bus(16'hFFFF, 300);
        wait_bus(16'h0010, 3);
        rdchk(mcp_pkg::OFF_FLAGS, 16'h0100, 16'h0100);
        rdchk(mcp_pkg::OFF_PENDING, 16'h0100, 16'h0100);
        wr(mcp_pkg::OFF_COUNTER, 16'hFFF8);
        wr(mcp_pkg::OFF_MODULUS, 16'h0000);
        wait_bus(16'hFFFF, 20);
        wait_bus(16'h0000, 3);
        wait_bus(16'h0001, 3);
        wr(mcp_pkg::OFF_FLAGS, 16'h0000);
        wr(mcp_pkg::OFF_PENDING, 16'hFFFF);
        chk({15'h0000, bus_error_o}, 16'h0000);
        rdchk(mcp_pkg::OFF_PENDING, 16'h0000, 16'h0100);
        wr(mcp_pkg::OFF_CONFIG, 16'h0001);
        wr(mcp_pkg::OFF_PENDING, 16'hFFFF);
        chk({15'h0000, bus_error_o}, 16'h0001);
        idle(1);
        chk({15'h0000, bus_error_o}, 16'h0000);
    endtask : t_overflow

    // Polarity is switched only while the pin sits at the new idle level.
    task automatic t_ext();
        wr(mcp_pkg::OFF_CNT_CTRL, 16'h0008);
        wr(mcp_pkg::OFF_COUNTER, 16'h0100);
        u_mcp_pin_model.set_clk(1'b1);
        idle(8);
        chk(counter_bus_o, 16'h0101);
        wr(mcp_pkg::OFF_CNT_CTRL, 16'h0018);
        u_mcp_pin_model.set_clk(1'b0);
        idle(8);
        chk(counter_bus_o, 16'h0102);
        u_mcp_pin_model.set_clk(1'b1);
        idle(8);
        chk(counter_bus_o, 16'h0102);
        wr(mcp_pkg::OFF_MODULUS, 16'h0AAA);
        wr(mcp_pkg::OFF_CNT_CTRL, 16'h0058);
        idle(4);
        chk(counter_bus_o, 16'h0102);
        u_mcp_pin_model.set_load(1'b1);
        idle(8);
        chk(counter_bus_o, 16'h0AAA);
        wr(mcp_pkg::OFF_CNT_CTRL, 16'h0078);
        wr(mcp_pkg::OFF_MODULUS, 16'h0555);
        u_mcp_pin_model.set_load(1'b0);
        idle(8);
        chk(counter_bus_o, 16'h0555);
        wr(mcp_pkg::OFF_MODULUS, 16'h0777);
        u_mcp_pin_model.set_load(1'b1);
        idle(8);
        chk(counter_bus_o, 16'h0555);
    endtask : t_ext

    // Counter cycles 0xFFC0..0xFFFF; A leads at 0xFFD0, B trails.
    task automatic t_pwm();
        wr(mcp_pkg::OFF_CNT_CTRL, 16'h0000);
        wr(mcp_pkg::OFF_DA_A, 16'hFFD0);
        wr(mcp_pkg::OFF_DA_B, 16'hFFE0);
        wr(mcp_pkg::OFF_DA_CTRL, 16'h000F);
        wr(mcp_pkg::OFF_COUNTER, 16'hFFC0);
        wait_bus(16'hFFD8, 80);
        chk_pwm(1'b1);
        wait_bus(16'hFFF0, 40);
        chk_pwm(1'b0);
        rdchk(mcp_pkg::OFF_FLAGS, 16'h0010, 16'h0010);
        wr(mcp_pkg::OFF_DA_B, 16'hFFE8);
        rdchk(mcp_pkg::OFF_DA_B, 16'hFFE8, 16'hFFFF);
        wait_bus(16'hFFC5, 80);
        wait_bus(16'hFFE4, 40);
        chk_pwm(1'b1);
        wait_bus(16'hFFEC, 10);
        chk_pwm(1'b0);
    endtask : t_pwm

    task automatic t_force();
        wr(mcp_pkg::OFF_CNT_CTRL, 16'h0008);
        wr(mcp_pkg::OFF_DA_CTRL, 16'h0020);
        idle(2);
        chk_pwm(1'b1);
        rdchk(mcp_pkg::OFF_DA_CTRL, 16'h0000, 16'h0060);
        wr(mcp_pkg::OFF_DA_CTRL, 16'h0040);
        idle(2);
        chk_pwm(1'b0);
    endtask : t_force

    // Clock enable low freezes the running counter and ignores writes.
    task automatic t_freeze();
        wr(mcp_pkg::OFF_CNT_CTRL, 16'h0000);
        wr(mcp_pkg::OFF_COUNTER, 16'h1000);
        @(posedge ref_clk_i);
        clk_en_i <= 1'b0;
        #1;
        chk(counter_bus_o, 16'h1001);
        wr(mcp_pkg::OFF_COUNTER, 16'h0ABC);
        idle(4);
        chk(counter_bus_o, 16'h1001);
        @(posedge ref_clk_i);
        clk_en_i <= 1'b1;
        idle(3);
        chk(counter_bus_o, 16'h1004);
    endtask : t_freeze

    // ------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        repeat (3) @(posedge ref_clk_i);
        reset_i <= 1'b0;
        idle(1);
        t_reset();
        t_loads();
        t_overflow();
        t_ext();
        t_pwm();
        t_force();
        t_freeze();
        conclude();
    end

    initial begin
        #(100 * 20000);
        num_errors++;
        conclude();
    end
endmodule : mcp_counter_pwm_bench

/* File: verification/mcp_pin_model.sv */
// Behavioural model of the external clock and load pins of the counter.
`timescale 1ns/1ps
module mcp_pin_model (
    input wire logic ref_clk_i,
    output logic ext_clk_o,
    output logic ext_load_o
);
    // Both pins are actively driven, so they simply hold their last level.
    initial begin
        ext_clk_o = 1'b0;
        ext_load_o = 1'b0;
    end

    task automatic set_clk(input logic v);
        @(posedge ref_clk_i);
        ext_clk_o <= v;
    endtask : set_clk

    task automatic set_load(input logic v);
        @(posedge ref_clk_i);
        ext_load_o <= v;
    endtask : set_load
endmodule : mcp_pin_model
